// ==== src/hprdy_consts.svh ====
// timing counts, widths and fixed values for the host port ready handshake
// assumes a single 50 MHz clock shared by both ends
//
// Functional notes
// - host holds strobe past minimum and ready
// - host releases read only after ready
// - ready driven only while chip selected
// - host waits 325 ns after two-byte read before a read of another address
// - host waits 600/900 ns after write before a read of another address
// - other cases need only 10 ns
// - read ready low bounded by history terms
// - write ready low bounded by history terms
// - gap modes add 200 or 775 ns
// - counter low byte with widen set is two-byte
// - strobes count only while selected
// - host holds write until ready, waits
`ifndef HPRDY_CONSTS_SVH
`define HPRDY_CONSTS_SVH

`define HPRDY_CLK_MHZ 50
`define HPRDY_CYC(ns_v) (((ns_v) * `HPRDY_CLK_MHZ + 999) / 1000)
`define HPRDY_CYC_DN(ns_v) (((ns_v) * `HPRDY_CLK_MHZ) / 1000)

// least times, rounded up
`define HPRDY_RD_LOW_NS 40
`define HPRDY_WR_LOW_NS 20
`define HPRDY_GAP_NS 10
`define HPRDY_RD2_GAP_NS 325
`define HPRDY_WR1_GAP_NS 600
`define HPRDY_WR2_GAP_NS 900
// ready round trip through both synchronisers, in cycles
`define HPRDY_RDY_TRIP_CYC 4
`define HPRDY_RD_LOW_CYC `HPRDY_CYC(`HPRDY_RD_LOW_NS)
`define HPRDY_WR_LOW_CYC `HPRDY_CYC(`HPRDY_WR_LOW_NS)
`define HPRDY_GAP_CYC `HPRDY_CYC(`HPRDY_GAP_NS)
`define HPRDY_RD2_GAP_CYC `HPRDY_CYC(`HPRDY_RD2_GAP_NS)
`define HPRDY_WR1_GAP_CYC `HPRDY_CYC(`HPRDY_WR1_GAP_NS)
`define HPRDY_WR2_GAP_CYC `HPRDY_CYC(`HPRDY_WR2_GAP_NS)

// ready-low terms, rounded down
`define HPRDY_RD_BASE_NS 600
`define HPRDY_RD_RD2_NS 65
`define HPRDY_RD_WR1_NS 310
`define HPRDY_RD_WR2_NS 620
`define HPRDY_WR_RD2_NS 350
`define HPRDY_WR_WR2_NS 900
`define HPRDY_WR_WR1_NS 600
`define HPRDY_RD_BASE_CYC `HPRDY_CYC_DN(`HPRDY_RD_BASE_NS)
`define HPRDY_RD_RD2_CYC `HPRDY_CYC_DN(`HPRDY_RD_RD2_NS)
`define HPRDY_RD_WR1_CYC `HPRDY_CYC_DN(`HPRDY_RD_WR1_NS)
`define HPRDY_RD_WR2_CYC `HPRDY_CYC_DN(`HPRDY_RD_WR2_NS)
`define HPRDY_WR_RD2_CYC `HPRDY_CYC_DN(`HPRDY_WR_RD2_NS)
`define HPRDY_WR_WR2_CYC `HPRDY_CYC_DN(`HPRDY_WR_WR2_NS)
`define HPRDY_WR_WR1_CYC `HPRDY_CYC_DN(`HPRDY_WR_WR1_NS)

// gap mode extras
`define HPRDY_GAP_EVEN_NS 200
`define HPRDY_GAP_ROW_NS 775
`define HPRDY_GAP_EVEN_CYC `HPRDY_CYC(`HPRDY_GAP_EVEN_NS)
`define HPRDY_GAP_ROW_CYC `HPRDY_CYC(`HPRDY_GAP_ROW_NS)

// widths and fixed values
`define HPRDY_AW 9
`define HPRDY_DW 8
`define HPRDY_CW 7
`define HPRDY_CNT_MAX 7'h7f
`define HPRDY_DATA_RST 8'h00
`define HPRDY_CTR_LO_ADDR 9'h010
`define HPRDY_CTR_LO_NUM 8

`endif

// ==== src/hprdy_pkg.sv ====
// types shared by both ends of the host port ready handshake
// assumes nothing of its surroundings
package hprdy_pkg;
    typedef enum logic [1:0] {
        HPRDY_GAP_NONE = 2'b00,
        HPRDY_GAP_EVEN = 2'b01,
        HPRDY_GAP_ROW = 2'b10
    } hprdy_gap_e;
    typedef enum logic [1:0] {
        HPRDY_DEV_IDLE = 2'b00,
        HPRDY_DEV_BUSY = 2'b01,
        HPRDY_DEV_DONE = 2'b10
    } hprdy_dev_e;
    typedef enum logic [2:0] {
        HPRDY_HST_IDLE = 3'b000,
        HPRDY_HST_SEL = 3'b001,
        HPRDY_HST_STRB = 3'b010,
        HPRDY_HST_END = 3'b011,
        HPRDY_HST_GAP = 3'b100
    } hprdy_hst_e;
endpackage

// ==== src/hprdy_if.sv ====
// pin bundle between processor and device
// assumes the testbench resolves the ready wire from its enable
`timescale 1ns/1ps
interface hprdy_if;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rdata_oe;
    logic rdy_o;
    logic rdy_oe;
    logic rdy_i;
    modport dev (input sel_n, rd_n, wr_n, addr, wdata, rdy_i,
                 output rdata, rdata_oe, rdy_o, rdy_oe);
    modport host (output sel_n, rd_n, wr_n, addr, wdata,
                  input rdata, rdata_oe, rdy_i);
endinterface

// ==== src/hprdy_dev.sv ====
// device end: stretches strobes with ready, keeps access history
// assumes pins come from another domain; user side is the register store
`timescale 1ns/1ps
`include "hprdy_consts.svh"
module hprdy_dev (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    hprdy_if.dev pin,
    // configuration
    input wire logic counter_wide_enable,
    input wire hprdy_pkg::hprdy_gap_e gap_mode,
    // register store side
    output logic acc_stb,
    output logic acc_wr,
    output logic [8:0] acc_addr,
    output logic [7:0] acc_wdata,
    input wire logic [7:0] acc_rdata
);
    typedef logic [6:0] hprdy_cnt_t;

    function automatic hprdy_cnt_t left(input hprdy_cnt_t lim, input hprdy_cnt_t age);
        left = (age >= lim) ? 7'h00 : hprdy_cnt_t'(lim - age);
    endfunction

    function automatic hprdy_cnt_t bump(input hprdy_cnt_t c);
        bump = (c == `HPRDY_CNT_MAX) ? c : hprdy_cnt_t'(c + 7'h01);
    endfunction

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [2:0] s1_r, s2_r, s3_r;
    logic [8:0] a1_r, a2_r;
    logic [7:0] d1_r, d2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            s3_r <= 3'h7;
            a1_r <= 9'h000;
            a2_r <= 9'h000;
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            s1_r <= {pin.sel_n, pin.rd_n, pin.wr_n};
            s2_r <= s1_r;
            s3_r <= s2_r;
            a1_r <= pin.addr;
            a2_r <= a1_r;
            d1_r <= pin.wdata;
            d2_r <= d1_r;
        end
    end
    logic sel, rd, wr, rd_fall, wr_fall, wr_rise;
    assign sel = !s2_r[2];
    assign rd = sel && !s2_r[1];
    assign wr = sel && !s2_r[0];
    assign rd_fall = rd && s3_r[1];
    assign wr_fall = wr && s3_r[0];
    assign wr_rise = sel && s2_r[0] && !s3_r[0];

    // --------------------------------------------------------------
    // handshake state and history
    // --------------------------------------------------------------
    hprdy_pkg::hprdy_dev_e st_r, st_nxt;
    hprdy_cnt_t wait_r, wait_nxt, rd2_r, rd2_nxt, wr1_r, wr1_nxt, wr2_r, wr2_nxt;
    logic [8:0] rd2a_r, rd2a_nxt, wr1a_r, wr1a_nxt, wr2a_r, wr2a_nxt, cur_r, cur_nxt;
    logic wide_r, wide_nxt, isw_r, isw_nxt;
    logic rdy_r, rdy_nxt, oe_r, oe_nxt, doe_r, doe_nxt, stb_r, stb_nxt;
    logic [7:0] rdat_r, rdat_nxt, wdat_r, wdat_nxt;
    hprdy_cnt_t extra, hold_rd, hold_wr, m1, m2, m3;
    logic two;

    always_comb begin
        unique case (gap_mode)
            hprdy_pkg::HPRDY_GAP_EVEN: extra = hprdy_cnt_t'(`HPRDY_GAP_EVEN_CYC);
            hprdy_pkg::HPRDY_GAP_ROW: extra = hprdy_cnt_t'(`HPRDY_GAP_ROW_CYC);
            default: extra = 7'h00;
        endcase
        two = counter_wide_enable && (a2_r[8:3] == 6'(`HPRDY_CTR_LO_ADDR >> 3)) && !a2_r[0];
        m1 = (rd2a_r == a2_r) ? left(hprdy_cnt_t'(`HPRDY_RD_RD2_CYC), rd2_r) : 7'h00;
        m2 = (wr1a_r == a2_r) ? left(hprdy_cnt_t'(`HPRDY_RD_WR1_CYC), wr1_r) : 7'h00;
        m3 = (wr2a_r == a2_r) ? left(hprdy_cnt_t'(`HPRDY_RD_WR2_CYC), wr2_r) : 7'h00;
        hold_rd = (m1 > m2) ? m1 : m2;
        hold_rd = (m3 > hold_rd) ? m3 : hold_rd;
        hold_rd = hprdy_cnt_t'(hold_rd + `HPRDY_RD_BASE_CYC);
        m1 = (rd2a_r == a2_r) ? left(hprdy_cnt_t'(`HPRDY_WR_RD2_CYC), rd2_r) : 7'h00;
        m2 = left(hprdy_cnt_t'(`HPRDY_WR_WR2_CYC), wr2_r);
        m3 = left(hprdy_cnt_t'(`HPRDY_WR_WR1_CYC), wr1_r);
        hold_wr = (m1 > m2) ? m1 : m2;
        hold_wr = (m3 > hold_wr) ? m3 : hold_wr;
        st_nxt = st_r;
        wait_nxt = (wait_r != 7'h00) ? hprdy_cnt_t'(wait_r - 7'h01) : 7'h00;
        rd2_nxt = bump(rd2_r);
        wr1_nxt = bump(wr1_r);
        wr2_nxt = bump(wr2_r);
        rd2a_nxt = rd2a_r;
        wr1a_nxt = wr1a_r;
        wr2a_nxt = wr2a_r;
        cur_nxt = cur_r;
        wide_nxt = wide_r;
        isw_nxt = isw_r;
        rdy_nxt = rdy_r;
        rdat_nxt = rdat_r;
        wdat_nxt = wdat_r;
        stb_nxt = 1'b0;
        oe_nxt = sel;
        doe_nxt = rd && (st_r == hprdy_pkg::HPRDY_DEV_DONE);
        unique case (st_r)
            hprdy_pkg::HPRDY_DEV_IDLE: begin
                rdy_nxt = 1'b1;
                if (rd_fall || wr_fall) begin
                    rdy_nxt = 1'b0;
                    cur_nxt = a2_r;
                    wide_nxt = two;
                    isw_nxt = wr_fall;
                    wait_nxt = hprdy_cnt_t'((wr_fall ? hold_wr : hold_rd) + extra);
                    st_nxt = hprdy_pkg::HPRDY_DEV_BUSY;
                end
            end
            hprdy_pkg::HPRDY_DEV_BUSY: begin
                if (wait_r == 7'h00) begin
                    stb_nxt = 1'b1;
                    wdat_nxt = d2_r;
                    rdat_nxt = isw_r ? rdat_r : acc_rdata;
                    st_nxt = hprdy_pkg::HPRDY_DEV_DONE;
                end
            end
            hprdy_pkg::HPRDY_DEV_DONE: begin
                rdy_nxt = 1'b1;
                if (isw_r && (wr_rise || !sel)) begin
                    if (wide_r) begin
                        wr2_nxt = 7'h00;
                        wr2a_nxt = cur_r;
                    end else begin
                        wr1_nxt = 7'h00;
                        wr1a_nxt = cur_r;
                    end
                    st_nxt = hprdy_pkg::HPRDY_DEV_IDLE;
                end else if (!isw_r && !rd) begin
                    st_nxt = hprdy_pkg::HPRDY_DEV_IDLE;
                end
                if (!isw_r && rdy_r == 1'b0 && wide_r) begin
                    rd2_nxt = 7'h00;
                    rd2a_nxt = cur_r;
                end
            end
            default: st_nxt = hprdy_pkg::HPRDY_DEV_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= hprdy_pkg::HPRDY_DEV_IDLE;
            wait_r <= 7'h00;
            rd2_r <= `HPRDY_CNT_MAX;
            wr1_r <= `HPRDY_CNT_MAX;
            wr2_r <= `HPRDY_CNT_MAX;
            rd2a_r <= 9'h000;
            wr1a_r <= 9'h000;
            wr2a_r <= 9'h000;
            cur_r <= 9'h000;
            wide_r <= 1'b0;
            isw_r <= 1'b0;
            rdy_r <= 1'b1;
            oe_r <= 1'b0;
            doe_r <= 1'b0;
            stb_r <= 1'b0;
            rdat_r <= `HPRDY_DATA_RST;
            wdat_r <= `HPRDY_DATA_RST;
        end else begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
            rd2_r <= rd2_nxt;
            wr1_r <= wr1_nxt;
            wr2_r <= wr2_nxt;
            rd2a_r <= rd2a_nxt;
            wr1a_r <= wr1a_nxt;
            wr2a_r <= wr2a_nxt;
            cur_r <= cur_nxt;
            wide_r <= wide_nxt;
            isw_r <= isw_nxt;
            rdy_r <= rdy_nxt;
            oe_r <= oe_nxt;
            doe_r <= doe_nxt;
            stb_r <= stb_nxt;
            rdat_r <= rdat_nxt;
            wdat_r <= wdat_nxt;
        end
    end

    assign pin.rdy_o = rdy_r;
    assign pin.rdy_oe = oe_r;
    assign pin.rdata = rdat_r;
    assign pin.rdata_oe = doe_r;
    assign acc_stb = stb_r;
    assign acc_wr = isw_r;
    assign acc_addr = cur_r;
    assign acc_wdata = wdat_r;
endmodule

// ==== src/hprdy_host.sv ====
// processor end: runs one strobe per request, waits for ready and gaps
// assumes ready wire resolved by the testbench, pulled high when undriven
`timescale 1ns/1ps
`include "hprdy_consts.svh"
module hprdy_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    hprdy_if.host pin,
    // configuration
    input wire logic counter_wide_enable,
    input wire hprdy_pkg::hprdy_gap_e gap_mode,
    // request and answer
    input wire logic req_valid,
    input wire logic req_wr,
    input wire logic [8:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata
);
    hprdy_pkg::hprdy_hst_e st_r, st_nxt;
    logic [6:0] cnt_r, cnt_nxt, gap_r, gap_nxt, extra;
    logic [8:0] a_r, a_nxt, last_r, last_nxt;
    logic [7:0] d_r, d_nxt, q_r, q_nxt;
    logic w_r, w_nxt, sel_r, sel_nxt, rd_r, rd_nxt, wrs_r, wrs_nxt;
    logic rv_r, rv_nxt, rq_r, rq_nxt, y1_r, y2_r, two;
    logic [7:0] r1_r, r2_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            y1_r <= 1'b1;
            y2_r <= 1'b1;
            r1_r <= `HPRDY_DATA_RST;
            r2_r <= `HPRDY_DATA_RST;
        end else begin
            y1_r <= pin.rdy_i;
            y2_r <= y1_r;
            r1_r <= pin.rdata;
            r2_r <= r1_r;
        end
    end

    always_comb begin
        unique case (gap_mode)
            hprdy_pkg::HPRDY_GAP_EVEN: extra = 7'(`HPRDY_GAP_EVEN_CYC);
            hprdy_pkg::HPRDY_GAP_ROW: extra = 7'(`HPRDY_GAP_ROW_CYC);
            default: extra = 7'h00;
        endcase
        two = counter_wide_enable && (a_r[8:3] == 6'(`HPRDY_CTR_LO_ADDR >> 3)) && !a_r[0];
        st_nxt = st_r;
        cnt_nxt = (cnt_r != 7'h00) ? 7'(cnt_r - 7'h01) : 7'h00;
        gap_nxt = gap_r;
        a_nxt = a_r;
        d_nxt = d_r;
        w_nxt = w_r;
        last_nxt = last_r;
        sel_nxt = sel_r;
        rd_nxt = rd_r;
        wrs_nxt = wrs_r;
        q_nxt = q_r;
        rv_nxt = 1'b0;
        rq_nxt = 1'b0;
        unique case (st_r)
            hprdy_pkg::HPRDY_HST_IDLE: begin
                rq_nxt = 1'b1;
                if (req_valid && rq_r) begin
                    rq_nxt = 1'b0;
                    a_nxt = req_addr;
                    d_nxt = req_wdata;
                    w_nxt = req_wr;
                    sel_nxt = 1'b0;
                    st_nxt = hprdy_pkg::HPRDY_HST_SEL;
                end
            end
            hprdy_pkg::HPRDY_HST_SEL: begin
                if (!w_r && a_r != last_r && cnt_r != 7'h00) begin
                    st_nxt = st_r;
                end else begin
                    rd_nxt = w_r;
                    wrs_nxt = !w_r;
                    // strobe outlasts the ready round trip, so a stale high ready is never taken
                    cnt_nxt = w_r ? 7'(`HPRDY_WR_LOW_CYC + `HPRDY_RDY_TRIP_CYC) :
                        7'(`HPRDY_RD_LOW_CYC + `HPRDY_RDY_TRIP_CYC);
                    st_nxt = hprdy_pkg::HPRDY_HST_STRB;
                end
            end
            hprdy_pkg::HPRDY_HST_STRB: begin
                if (cnt_r == 7'h00 && y2_r) begin
                    q_nxt = r2_r;
                    rd_nxt = 1'b1;
                    wrs_nxt = 1'b1;
                    st_nxt = hprdy_pkg::HPRDY_HST_END;
                end
            end
            hprdy_pkg::HPRDY_HST_END: begin
                rv_nxt = !w_r;
                sel_nxt = 1'b1;
                last_nxt = a_r;
                if (w_r) begin
                    gap_nxt = two ? 7'(`HPRDY_WR2_GAP_CYC) : 7'(`HPRDY_WR1_GAP_CYC);
                end else begin
                    gap_nxt = two ? 7'(`HPRDY_RD2_GAP_CYC) : 7'(`HPRDY_GAP_CYC);
                end
                cnt_nxt = 7'(`HPRDY_GAP_CYC);
                st_nxt = hprdy_pkg::HPRDY_HST_GAP;
            end
            hprdy_pkg::HPRDY_HST_GAP: begin
                if (cnt_r == 7'h00) begin
                    cnt_nxt = 7'(gap_r + extra - `HPRDY_GAP_CYC);
                    rq_nxt = 1'b1;
                    st_nxt = hprdy_pkg::HPRDY_HST_IDLE;
                end
            end
            default: st_nxt = hprdy_pkg::HPRDY_HST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= hprdy_pkg::HPRDY_HST_IDLE;
            cnt_r <= 7'h00;
            gap_r <= 7'h00;
            a_r <= 9'h000;
            last_r <= 9'h000;
            d_r <= `HPRDY_DATA_RST;
            q_r <= `HPRDY_DATA_RST;
            w_r <= 1'b0;
            sel_r <= 1'b1;
            rd_r <= 1'b1;
            wrs_r <= 1'b1;
            rv_r <= 1'b0;
            rq_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            a_r <= a_nxt;
            last_r <= last_nxt;
            d_r <= d_nxt;
            q_r <= q_nxt;
            w_r <= w_nxt;
            sel_r <= sel_nxt;
            rd_r <= rd_nxt;
            wrs_r <= wrs_nxt;
            rv_r <= rv_nxt;
            rq_r <= rq_nxt;
        end
    end

    assign pin.sel_n = sel_r;
    assign pin.rd_n = rd_r;
    assign pin.wr_n = wrs_r;
    assign pin.addr = a_r;
    assign pin.wdata = d_r;
    assign req_ready = rq_r;
    assign rsp_valid = rv_r;
    assign rsp_rdata = q_r;
endmodule

// ==== bench/hprdy_sva.sv ====
// checker for the pin bundle between processor end and device end
// assumes it sits beside the interface, fed with its signals and the configuration
`timescale 1ns/1ps
`include "hprdy_consts.svh"
module hprdy_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic counter_wide_enable,
    input wire hprdy_pkg::hprdy_gap_e gap_mode,
    // pins
    input wire logic sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [8:0] addr,
    input wire logic rdata_oe,
    input wire logic rdy_o,
    input wire logic rdy_oe,
    input wire logic rdy_i
);
    // ----------------------------------------
    // history of the last access
    // ----------------------------------------
    logic wr_prev_r, wr_prev_nxt, rdy_prev_r, rdy_prev_nxt, wr_rise, rd_end, two;
    logic [7:0] low_cnt_r, low_cnt_nxt, cnt_r, cnt_nxt, need_r, need_nxt;
    logic [8:0] last_r, last_nxt;
    int extra_ns, lim_rd, lim_wr;

    always_comb begin
        extra_ns = 0;
        if (gap_mode == hprdy_pkg::HPRDY_GAP_EVEN) extra_ns = `HPRDY_GAP_EVEN_NS;
        if (gap_mode == hprdy_pkg::HPRDY_GAP_ROW) extra_ns = `HPRDY_GAP_ROW_NS;
        lim_rd = `HPRDY_CYC(`HPRDY_RD_BASE_NS + `HPRDY_RD_WR2_NS + extra_ns) + 2;
        lim_wr = `HPRDY_CYC(`HPRDY_WR_WR2_NS + extra_ns) + 2;
        two = counter_wide_enable && !addr[0] && addr >= `HPRDY_CTR_LO_ADDR &&
            addr < `HPRDY_CTR_LO_ADDR + `HPRDY_CTR_LO_NUM;
        wr_rise = wr_n && !wr_prev_r;
        rd_end = rdy_o && !rdy_prev_r && !rd_n && !sel_n;
        wr_prev_nxt = wr_n;
        rdy_prev_nxt = rdy_o;
        low_cnt_nxt = (rdy_oe && !rdy_o) ? low_cnt_r + {7'h00, low_cnt_r != 8'hff} : 8'h00;
        cnt_nxt = cnt_r + {7'h00, cnt_r != 8'hff};
        need_nxt = need_r;
        last_nxt = last_r;
        if (wr_rise || rd_end) begin
            cnt_nxt = 8'h01;
            last_nxt = addr;
        end
        if (wr_rise) begin
            need_nxt = 8'(two ? `HPRDY_CYC(`HPRDY_WR2_GAP_NS + extra_ns) :
                `HPRDY_CYC(`HPRDY_WR1_GAP_NS + extra_ns));
        end else if (rd_end) begin
            need_nxt = two ? 8'(`HPRDY_CYC(`HPRDY_RD2_GAP_NS + extra_ns)) : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_r <= 1'b1;
            rdy_prev_r <= 1'b1;
            low_cnt_r <= 8'h00;
            cnt_r <= 8'hff;
            need_r <= 8'h00;
            last_r <= 9'h000;
        end else begin
            wr_prev_r <= wr_prev_nxt;
            rdy_prev_r <= rdy_prev_nxt;
            low_cnt_r <= low_cnt_nxt;
            cnt_r <= cnt_nxt;
            need_r <= need_nxt;
            last_r <= last_nxt;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_fall;
        !sel_n && $fell(rd_n);
    endsequence
    sequence s_strb_fall;
        !sel_n && ($fell(rd_n) || $fell(wr_n));
    endsequence
    sequence s_rdy_rise;
        !sel_n && !rd_n && $rose(rdy_o);
    endsequence

    chk_oe_idle_desel: assert property (sel_n [*5] |-> !rdy_oe)
        else $error("ready driven while deselected");
    chk_oe_drive_sel: assert property (!sel_n [*5] |-> rdy_oe)
        else $error("ready not driven while selected");
    chk_rdy_falls_strobe: assert property (s_strb_fall |-> ##[1:6] !rdy_o)
        else $error("ready not pulled low after strobe");
    chk_rd_hold_rdy: assert property ($rose(rd_n) |-> $past(rdy_i) && $past(rdy_i, 2))
        else $error("read strobe released before ready");
    chk_wr_hold_rdy: assert property ($rose(wr_n) |-> $past(rdy_i) && $past(rdy_i, 2))
        else $error("write strobe released before ready");
    chk_rd_low_min: assert property (s_rd_fall |-> !rd_n [*2])
        else $error("read strobe too short");
    chk_data_at_rdy: assert property (s_rdy_rise |-> rdata_oe)
        else $error("ready rose without read data");
    chk_rd_low_max: assert property (!sel_n && !rd_n |-> low_cnt_r <= lim_rd)
        else $error("ready low too long on read");
    chk_wr_low_max: assert property (!sel_n && !wr_n |-> low_cnt_r <= lim_wr)
        else $error("ready low too long on write");
    chk_gap_next_rd: assert property (s_rd_fall ##0 addr != last_r |-> cnt_r >= need_r)
        else $error("read started too soon after access");
endmodule

// ==== bench/host_port_ready_handshake_test.sv ====
// testbench: both ends joined across the pin bundle, with a register store
// assumes package, header, interface, both ends and the checker compile first
`timescale 1ns/1ps
module host_port_ready_handshake_test;
    // ----------------------------------------
    // signals and table
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [8:0] addr;
        logic [7:0] data;
        logic cwe;
        hprdy_pkg::hprdy_gap_e gap;
    } hprdy_row_s;
    localparam hprdy_pkg::hprdy_gap_e GN = hprdy_pkg::HPRDY_GAP_NONE;
    localparam hprdy_pkg::hprdy_gap_e GE = hprdy_pkg::HPRDY_GAP_EVEN;
    localparam hprdy_pkg::hprdy_gap_e GR = hprdy_pkg::HPRDY_GAP_ROW;
    logic clk, rst_n, cwe, req_valid, req_wr, req_ready, rsp_valid, acc_stb, acc_wr;
    logic [8:0] req_addr, acc_addr;
    logic [7:0] req_wdata, rsp_rdata, acc_wdata, acc_rdata;
    logic [7:0] mem [0:15];
    hprdy_pkg::hprdy_gap_e gap_mode;
    int fails, cmp_count;
    hprdy_row_s rows [0:13];

    hprdy_if bus ();
    assign bus.rdy_i = bus.rdy_oe ? bus.rdy_o : 1'b1;
    assign acc_rdata = mem[bus.addr[3:0]];
    always #10 clk = ~clk;

    hprdy_dev u_hprdy_dev (.clk(clk), .rst_n(rst_n), .pin(bus), .counter_wide_enable(cwe),
        .gap_mode(gap_mode), .acc_stb(acc_stb), .acc_wr(acc_wr), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));
    hprdy_host u_hprdy_host (.clk(clk), .rst_n(rst_n), .pin(bus), .counter_wide_enable(cwe),
        .gap_mode(gap_mode), .req_valid(req_valid), .req_wr(req_wr), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    hprdy_sva u_hprdy_sva (.clk(clk), .rst_n(rst_n), .counter_wide_enable(cwe),
        .gap_mode(gap_mode), .sel_n(bus.sel_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .addr(bus.addr), .rdata_oe(bus.rdata_oe), .rdy_o(bus.rdy_o), .rdy_oe(bus.rdy_oe),
        .rdy_i(bus.rdy_i));

    // store behind the device
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
        end else if (acc_stb === 1'b1 && acc_wr === 1'b1) begin
            mem[acc_addr[3:0]] <= acc_wdata;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic take(input hprdy_row_s r);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        cwe <= r.cwe;
        gap_mode <= r.gap;
        req_valid <= 1'b1;
        req_wr <= r.wr;
        req_addr <= r.addr;
        req_wdata <= r.data;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        req_valid <= 1'b0;
    endtask

    task automatic do_op(input hprdy_row_s r);
        int n;
        logic got, sw;
        logic [8:0] sa;
        logic [7:0] sd;
        n = 0;
        got = 1'b0;
        take(r);
        do begin
            @(posedge clk);
            n++;
            if (acc_stb === 1'b1) begin
                got = 1'b1;
                sw = acc_wr;
                sa = acc_addr;
                sd = acc_wdata;
            end
        end while (!(r.wr ? got : rsp_valid === 1'b1) && n < 400);
        check("acc_stb", got, 1'b1);
        check("acc_wr", sw, r.wr);
        check("acc_addr", sa, r.addr);
        if (r.wr) check("acc_wdata", sd, r.data);
        else check("rsp_rdata", rsp_rdata, r.data);
    endtask

    task automatic reset_check();
        check("reset_pins", {bus.sel_n, bus.rd_n, bus.wr_n, bus.rdy_oe, bus.rdata_oe, acc_stb,
            req_ready, rsp_valid}, 9'h0e0);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        cwe = 1'b0;
        gap_mode = GN;
        req_valid = 1'b0;
        req_wr = 1'b0;
        req_addr = 9'h000;
        req_wdata = 8'h00;
        fails = 0;
        cmp_count = 0;
        rows = '{'{1'b1, 9'h003, 8'h5a, 1'b0, GN}, '{1'b0, 9'h004, 8'h00, 1'b0, GN},
            '{1'b0, 9'h003, 8'h5a, 1'b0, GN}, '{1'b1, 9'h010, 8'ha5, 1'b1, GN},
            '{1'b0, 9'h003, 8'h5a, 1'b1, GN}, '{1'b0, 9'h010, 8'ha5, 1'b1, GN},
            '{1'b0, 9'h005, 8'h00, 1'b1, GN}, '{1'b1, 9'h011, 8'hc3, 1'b1, GN},
            '{1'b1, 9'h016, 8'h3c, 1'b1, GE}, '{1'b0, 9'h001, 8'hc3, 1'b1, GE},
            '{1'b1, 9'h014, 8'h99, 1'b1, GR}, '{1'b0, 9'h006, 8'h3c, 1'b1, GR},
            '{1'b1, 9'h018, 8'h77, 1'b1, GN}, '{1'b0, 9'h018, 8'h77, 1'b1, GN}};
        repeat (4) @(posedge clk);
        reset_check();
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) do_op(rows[i]);
        repeat (6) @(posedge clk);
        check("rdy_oe", bus.rdy_oe, 1'b0);
        check("rdy_i", bus.rdy_i, 1'b1);
        // reset during a read in flight
        take('{1'b0, 9'h003, 8'h00, 1'b0, GN});
        repeat (10) @(posedge clk);
        check("rd_mid", bus.rd_n, 1'b0);
        rst_n <= 1'b0;
        @(posedge clk);
        reset_check();
        repeat (7) @(posedge clk);
        rst_n <= 1'b1;
        do_op('{1'b0, 9'h003, 8'h00, 1'b0, GN});
        close_out();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
